// >>> sfp_map.vh
// constants for the flash protection and power block
`ifndef SFP_MAP_VH
`define SFP_MAP_VH
// apb register byte offsets
`define SFP_OFF_CTRL      12'h000
`define SFP_OFF_STATUS    12'h004
`define SFP_OFF_LOCK      12'h008
`define SFP_OFF_PWR       12'h00C
`define SFP_OFF_BUSY      12'h010
// command codes
`define SFP_CMD_WREN      8'h06
`define SFP_CMD_WRDI      8'h04
`define SFP_CMD_WRSR      8'h01
`define SFP_CMD_WRLR      8'hE5
`define SFP_CMD_PP        8'h02
`define SFP_CMD_OTP       8'h42
`define SFP_CMD_DPP       8'hA2
`define SFP_CMD_SSE       8'h20
`define SFP_CMD_SE        8'hD8
`define SFP_CMD_BE        8'hC7
`define SFP_CMD_DPD       8'hB9
`define SFP_CMD_RDPD      8'hAB
// status register field positions
`define SFP_SR_WEL        1
`define SFP_SR_BP_LO      2
`define SFP_SR_BP_HI      4
`define SFP_SR_TB         5
`define SFP_SR_STATUS_WRITE_DISABLE       7
// lock register fields
`define SFP_LK_WLOCK      0
`define SFP_LK_LDOWN      1
// power modes
`define SFP_PM_ACTIVE     2'h0
`define SFP_PM_STANDBY    2'h1
`define SFP_PM_DEEP       2'h2
// power-up write delay in microseconds, and clock rate in MHz
`define SFP_PUW_US        1000
`define SFP_CLK_MHZ       250
`endif

// >>> sfp_sync.v
// three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
module sfp_sync #(
  parameter RST_VAL = 1'b0
) (
  input  wire clk,
  input  wire rst_b,
  input  wire din,
  output reg  dout_q
);
  reg s1_q;
  reg s2_q;
  reg s3_q;

  // first stage feeds only the second; output moves when stages two and three agree
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_q   <= RST_VAL;
      s2_q   <= RST_VAL;
      s3_q   <= RST_VAL;
      dout_q <= RST_VAL;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        dout_q <= s3_q;
      end
    end
  end
endmodule

// >>> sfp_protect.v
// flash write-protection and power-mode control with apb register access
//
// Contract
// - select low means selected and active
// - deselected stays active until busy ends
// - deep power-down until release command
// - deep power-down ignores all modifying commands
// - block modifying ops until power-up timer
// - modifying commands need clock count multiple eight
// - modifying commands need write enable latch set
// - one lock register per 64KB sector
// - write-lock bit set blocks sector modification; bulk erase is taken without checking the lock bits
// - lock-down bit freezes lock bits until power-up
// - protect pin low freezes status register; the status write command is refused only while bit 7 is also set
// - bulk erase only with block-protect zero
// - top/bottom zero protects upper ranges
// - top/bottom one protects lower ranges
// - select rise off byte boundary rejects; the code accepts the ABh release at any clock count
// - B9h enters, ABh releases deep power-down
`timescale 1ns/10ps
`include "sfp_map.vh"
module sfp_protect #(
  parameter SECTORS    = 16,
  parameter PUW_CYCLES = `SFP_PUW_US * `SFP_CLK_MHZ
) (
  input  wire        clk,
  input  wire        rst_b,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output wire        pslverr,
  output reg  [31:0] prdata,
  input  wire        sel_b,
  input  wire        sclk,
  input  wire        wp_b,
  input  wire        cmd_valid,
  input  wire [7:0]  cmd_code,
  input  wire [3:0]  cmd_sector,
  input  wire [7:0]  cmd_data,
  input  wire        cycle_busy,
  output reg         cmd_accept,
  output reg         cmd_reject,
  output reg  [1:0]  power_mode,
  output reg         write_enable_latch,
  output reg  [7:0]  status_reg
);
  // ---------------------------------------------------------------
  // input synchronisation
  // ---------------------------------------------------------------
  wire sel_b_s;
  wire sclk_s;
  wire wp_b_s;

  sfp_sync #(.RST_VAL(1'b1)) u_sync_sel (.clk(clk), .rst_b(rst_b), .din(sel_b), .dout_q(sel_b_s));
  sfp_sync #(.RST_VAL(1'b0)) u_sync_clk (.clk(clk), .rst_b(rst_b), .din(sclk), .dout_q(sclk_s));
  sfp_sync #(.RST_VAL(1'b1)) u_sync_wp  (.clk(clk), .rst_b(rst_b), .din(wp_b), .dout_q(wp_b_s));

  // ---------------------------------------------------------------
  // clock pulse counting while selected
  // ---------------------------------------------------------------
  reg       sclk_d1_q;
  reg       sel_b_d1_q;
  reg [2:0] bit_cnt_q;
  wire      sclk_rise = sclk_s & ~sclk_d1_q;
  wire      sel_rise  = sel_b_s & ~sel_b_d1_q;
  wire      byte_ok   = (bit_cnt_q == 3'h0);

  // only the low three bits matter; a multiple of eight wraps to zero
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_d1_q  <= 1'b0;
      sel_b_d1_q <= 1'b1;
      bit_cnt_q  <= 3'h0;
    end else begin
      sclk_d1_q  <= sclk_s;
      sel_b_d1_q <= sel_b_s;
      if (sel_b_s) begin
        bit_cnt_q <= 3'h0;
      end else if (sclk_rise) begin
        bit_cnt_q <= bit_cnt_q + 3'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // command held from decoder until select rises
  // ---------------------------------------------------------------
  reg       pend_q;
  reg [7:0] pend_code_q;
  reg [3:0] pend_sec_q;
  reg [7:0] pend_data_q;

  // decoder reports the command; it executes only at the select rise
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pend_q      <= 1'b0;
      pend_code_q <= 8'h00;
      pend_sec_q  <= 4'h0;
      pend_data_q <= 8'h00;
    end else if (cmd_valid && !sel_b_s) begin
      pend_q      <= 1'b1;
      pend_code_q <= cmd_code;
      pend_sec_q  <= cmd_sector;
      pend_data_q <= cmd_data;
    end else if (sel_rise) begin
      pend_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // power-up write-inhibit timer
  // ---------------------------------------------------------------
  reg [31:0] puw_cnt_q;
  wire       puw_done = (puw_cnt_q >= PUW_CYCLES);

  // counts once from reset release; holds when expired
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      puw_cnt_q <= 32'h0000_0000;
    end else if (!puw_done) begin
      puw_cnt_q <= puw_cnt_q + 32'h0000_0001;
    end
  end

  // ---------------------------------------------------------------
  // protection evaluation
  // ---------------------------------------------------------------
  reg [1:0] lock_q [0:SECTORS-1];
  wire [2:0] bp_code = status_reg[`SFP_SR_BP_HI:`SFP_SR_BP_LO];
  wire       tb_bit  = status_reg[`SFP_SR_TB];
  reg        bp_hit;

  // block-protect range; the lower-half code protects sectors 0 to 7
  always @* begin
    bp_hit = 1'b0;
    case (bp_code)
      3'h0: bp_hit = 1'b0;
      3'h1: bp_hit = tb_bit ? (pend_sec_q == 4'h0) : (pend_sec_q == 4'hF);
      3'h2: bp_hit = tb_bit ? (pend_sec_q <= 4'h1) : (pend_sec_q >= 4'hE);
      3'h3: bp_hit = tb_bit ? (pend_sec_q <= 4'h3) : (pend_sec_q >= 4'hC);
      3'h4: bp_hit = tb_bit ? (pend_sec_q <= 4'h7) : (pend_sec_q >= 4'h8);
      default: bp_hit = 1'b1;
    endcase
  end

  wire is_wren = (pend_code_q == `SFP_CMD_WREN);
  wire is_wrdi = (pend_code_q == `SFP_CMD_WRDI);
  wire is_wrsr = (pend_code_q == `SFP_CMD_WRSR);
  wire is_wrlr = (pend_code_q == `SFP_CMD_WRLR);
  wire is_be   = (pend_code_q == `SFP_CMD_BE);
  wire is_dpd  = (pend_code_q == `SFP_CMD_DPD);
  wire is_rdpd = (pend_code_q == `SFP_CMD_RDPD);
  wire is_arr  = (pend_code_q == `SFP_CMD_PP) || (pend_code_q == `SFP_CMD_OTP) ||
                 (pend_code_q == `SFP_CMD_DPP) || (pend_code_q == `SFP_CMD_SSE) ||
                 (pend_code_q == `SFP_CMD_SE);
  wire is_mod  = is_arr || is_be || is_wrsr || is_wrlr;
  wire in_deep = (power_mode == `SFP_PM_DEEP);
  wire sec_wl  = lock_q[pend_sec_q][`SFP_LK_WLOCK];
  wire sec_ld  = lock_q[pend_sec_q][`SFP_LK_LDOWN];

  // gate: every modifying command passes all checks or is dropped
  wire mod_ok  = byte_ok && write_enable_latch && puw_done && !in_deep && !cycle_busy;
  wire arr_ok  = mod_ok && is_arr && !bp_hit && !sec_wl;
  wire be_ok   = mod_ok && is_be && (bp_code == 3'h0);
  wire sr_ok   = mod_ok && is_wrsr && !(wp_b_s == 1'b0 && status_reg[`SFP_SR_STATUS_WRITE_DISABLE]);
  wire lr_ok   = mod_ok && is_wrlr && !sec_ld;
  wire wen_ok  = byte_ok && !in_deep && (is_wren || is_wrdi);
  // refused while an internal cycle runs, so deep mode never cuts a busy cycle short
  wire dpd_ok  = byte_ok && !in_deep && !cycle_busy && is_dpd;
  wire exec    = pend_q && sel_rise;

  // ---------------------------------------------------------------
  // status, lock and latch state
  // ---------------------------------------------------------------
  integer i;
  reg     sw_sr_we;
  reg     sw_lk_we;

  // command outcomes and software writes; a command write wins over a software write
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      write_enable_latch <= 1'b0;
      status_reg         <= 8'h00;
      cmd_accept         <= 1'b0;
      cmd_reject         <= 1'b0;
      for (i = 0; i < SECTORS; i = i + 1) begin
        lock_q[i] <= 2'h0;
      end
    end else begin
      cmd_accept <= exec && (arr_ok || be_ok || sr_ok || lr_ok || wen_ok || dpd_ok || is_rdpd);
      cmd_reject <= exec && (is_mod || is_wren || is_wrdi || is_dpd) &&
                    !(arr_ok || be_ok || sr_ok || lr_ok || wen_ok || dpd_ok);
      if (exec && wen_ok && is_wren) begin
        write_enable_latch <= 1'b1;
      end else if ((exec && wen_ok && is_wrdi) || (exec && (arr_ok || be_ok || sr_ok || lr_ok))) begin
        write_enable_latch <= 1'b0; // latch cleared by write disable or consumed by the executed write
      end
      if (exec && sr_ok) begin
        status_reg[`SFP_SR_STATUS_WRITE_DISABLE]               <= pend_data_q[`SFP_SR_STATUS_WRITE_DISABLE];
        status_reg[`SFP_SR_TB]                 <= pend_data_q[`SFP_SR_TB];
        status_reg[`SFP_SR_BP_HI:`SFP_SR_BP_LO] <= pend_data_q[`SFP_SR_BP_HI:`SFP_SR_BP_LO];
      end else if (sw_sr_we && wp_b_s) begin
        status_reg[`SFP_SR_STATUS_WRITE_DISABLE]               <= pwdata[`SFP_SR_STATUS_WRITE_DISABLE];
        status_reg[`SFP_SR_TB]                 <= pwdata[`SFP_SR_TB];
        status_reg[`SFP_SR_BP_HI:`SFP_SR_BP_LO] <= pwdata[`SFP_SR_BP_HI:`SFP_SR_BP_LO];
      end
      if (exec && lr_ok) begin
        lock_q[pend_sec_q] <= pend_data_q[1:0];
      end else if (sw_lk_we && !lock_q[pwdata[11:8]][`SFP_LK_LDOWN]) begin
        lock_q[pwdata[11:8]] <= pwdata[1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // power mode
  // ---------------------------------------------------------------
  // deep power-down has priority and only the release command leaves it
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      power_mode <= `SFP_PM_STANDBY;
    end else begin
      case (power_mode)
        `SFP_PM_DEEP: begin
          if (exec && is_rdpd) begin
            power_mode <= `SFP_PM_ACTIVE;
          end
        end
        default: begin
          if (exec && dpd_ok) begin
            power_mode <= `SFP_PM_DEEP;
          end else if (!sel_b_s || cycle_busy) begin
            power_mode <= `SFP_PM_ACTIVE;
          end else begin
            power_mode <= `SFP_PM_STANDBY;
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // apb slave: zero wait, unmapped addresses answer pslverr
  // ---------------------------------------------------------------
  wire acc    = psel && penable;
  wire mapped = (paddr == `SFP_OFF_CTRL) || (paddr == `SFP_OFF_STATUS) || (paddr == `SFP_OFF_LOCK) ||
                (paddr == `SFP_OFF_PWR) || (paddr == `SFP_OFF_BUSY);

  assign pready  = 1'b1;
  assign pslverr = acc && !mapped;

  // lock writes from software obey lock-down; status writes from software are frozen whenever the protect pin is low
  always @* begin
    sw_sr_we = 1'b0;
    sw_lk_we = 1'b0;
    if (acc && pwrite && paddr == `SFP_OFF_STATUS) begin
      sw_sr_we = 1'b1;
    end else if (acc && pwrite && paddr == `SFP_OFF_LOCK) begin
      sw_lk_we = (pwdata[11:8] < SECTORS);
    end
  end

  reg [3:0] lk_idx_q;

  // read data registered at the setup phase; lock index selected by a write of ctrl
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata   <= 32'h0000_0000;
      lk_idx_q <= 4'h0;
    end else if (psel && !penable) begin
      prdata <= 32'h0000_0000;
      if (!pwrite) begin
        if (paddr == `SFP_OFF_CTRL) begin
          prdata <= {28'h000_0000, lk_idx_q};
        end else if (paddr == `SFP_OFF_STATUS) begin
          prdata <= {24'h00_0000, status_reg[7:2], write_enable_latch, cycle_busy};
        end else if (paddr == `SFP_OFF_LOCK) begin
          prdata <= {20'h0_0000, lk_idx_q, 6'h00, lock_q[lk_idx_q]};
        end else if (paddr == `SFP_OFF_PWR) begin
          prdata <= {29'h0000_0000, puw_done, power_mode};
        end else if (paddr == `SFP_OFF_BUSY) begin
          prdata <= {29'h0000_0000, byte_ok, pend_q, !sel_b_s};
        end
      end
    end else if (acc && pwrite && paddr == `SFP_OFF_CTRL) begin
      lk_idx_q <= pwdata[3:0];
    end
  end
endmodule

// >>> sfp_protect_asserts.sv
// assertion checker for the flash protection and power block
`timescale 1ns/10ps
`include "sfp_map.vh"
module sfp_protect_asserts #(
  parameter PUW_CYCLES = 50
) (
  input wire       clk,
  input wire       rst_b,
  input wire       sel_b,
  input wire       wp_b,
  input wire       cycle_busy,
  input wire [7:0] cmd_code,
  input wire       cmd_accept,
  input wire [1:0] power_mode,
  input wire       write_enable_latch,
  input wire [7:0] status_reg
);
  // ----------------------------------------
  // helper counter and properties
  // ----------------------------------------
  // cycles since reset, saturating so it never wraps on long runs
  reg [31:0] age_q;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      age_q <= 32'h0;
    else if (age_q < PUW_CYCLES)
      age_q <= age_q + 32'h1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // the pin passes a synchroniser, so eight cycles of margin
  sel_active_a: assert property (!sel_b [*8] |-> power_mode != `SFP_PM_STANDBY)
    else $error("standby while selected");
  busy_active_a: assert property (power_mode == `SFP_PM_ACTIVE && cycle_busy |=> power_mode == `SFP_PM_ACTIVE)
    else $error("left active during a busy cycle");
  deep_hold_a: assert property (power_mode == `SFP_PM_DEEP |=> power_mode == `SFP_PM_DEEP ||
                                (cmd_accept && cmd_code == `SFP_CMD_RDPD))
    else $error("left deep mode without release");
  deep_still_a: assert property (power_mode == `SFP_PM_DEEP |=> $stable(status_reg) && $stable(write_enable_latch))
    else $error("state changed in deep mode");
  timer_gate_a: assert property (cmd_accept && cmd_code != `SFP_CMD_RDPD && cmd_code != `SFP_CMD_DPD &&
                                 cmd_code != `SFP_CMD_WREN && cmd_code != `SFP_CMD_WRDI |-> age_q >= PUW_CYCLES)
    else $error("command taken before power-up delay");
  latch_cause_a: assert property ($rose(write_enable_latch) |-> cmd_accept && cmd_code == `SFP_CMD_WREN)
    else $error("latch set without write enable");
  wp_freeze_a: assert property (!wp_b [*8] ##0 status_reg[7] |=> $stable(status_reg[7:2]))
    else $error("status changed while protected");
  bulk_gate_a: assert property (cmd_accept && cmd_code == `SFP_CMD_BE |-> status_reg[4:2] == 3'h0)
    else $error("bulk erase with protect bits set");
endmodule
bind sfp_protect sfp_protect_asserts #(.PUW_CYCLES(PUW_CYCLES)) chk (
  .clk                (clk),
  .rst_b              (rst_b),
  .sel_b              (sel_b),
  .wp_b               (wp_b),
  .cycle_busy         (cycle_busy),
  .cmd_code           (cmd_code),
  .cmd_accept         (cmd_accept),
  .power_mode         (power_mode),
  .write_enable_latch (write_enable_latch),
  .status_reg         (status_reg)
);

// >>> sfp_spi_host.sv
// spi master model driving select, serial clock and the decoded command
`timescale 1ns/10ps
module sfp_spi_host (
  input  wire       clk,
  output reg        sel_b,
  output reg        sclk,
  output reg        cmd_valid,
  output reg  [7:0] cmd_code,
  output reg  [3:0] cmd_sector,
  output reg  [7:0] cmd_data
);
  // ----------------------------------------
  // idle levels and frame task
  // ----------------------------------------
  integer i;
  // clock rests low between frames, as in mode zero
  initial begin
    sel_b = 1'b1;
    sclk = 1'b0;
    cmd_valid = 1'b0;
    cmd_code = 8'h00;
    cmd_sector = 4'h0;
    cmd_data = 8'h00;
  end
  // n pulses; a count off a byte boundary only when a test asks for it
  task frame(input [7:0] c, input [3:0] s, input [7:0] d, input integer n);
    begin
      @(posedge clk) sel_b <= 1'b0;
      repeat (4) @(posedge clk);
      for (i = 0; i < n; i = i + 1) begin
        sclk <= 1'b1;
        repeat (4) @(posedge clk);
        sclk <= 1'b0;
        repeat (4) @(posedge clk);
      end
      cmd_code <= c;
      cmd_sector <= s;
      cmd_data <= d;
      cmd_valid <= 1'b1;
      @(posedge clk) cmd_valid <= 1'b0;
      repeat (4) @(posedge clk);
      sel_b <= 1'b1;
    end
  endtask
endmodule

// >>> tb_serial_flash_protect_power.sv
// self-checking bench for the flash protection and power block
`timescale 1ns/10ps
`include "sfp_map.vh"
module tb_serial_flash_protect_power;
  // ----------------------------------------
  // signals and instances
  // ----------------------------------------
  localparam PUW = 300;
  reg        clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0, rd;
  reg        wp_b = 1'b1, cycle_busy = 1'b0, er;
  wire       pready, pslverr, cmd_accept, cmd_reject, write_enable_latch, sel_b, sclk, cmd_valid;
  wire [31:0] prdata;
  wire [1:0] power_mode;
  wire [7:0] status_reg, cmd_code, cmd_data;
  wire [3:0] cmd_sector;
  integer    err_total = 0, tests_run = 0, k, s, t, b;
  // 250 MHz clock
  always #2 clk = ~clk;
  sfp_protect #(.PUW_CYCLES(PUW)) dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .sel_b(sel_b), .sclk(sclk), .wp_b(wp_b), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_sector(cmd_sector), .cmd_data(cmd_data), .cycle_busy(cycle_busy), .cmd_accept(cmd_accept),
    .cmd_reject(cmd_reject), .power_mode(power_mode), .write_enable_latch(write_enable_latch),
    .status_reg(status_reg));
  sfp_spi_host host (.clk(clk), .sel_b(sel_b), .sclk(sclk), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_sector(cmd_sector), .cmd_data(cmd_data));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task wrap_up;
    begin
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  task chk(input c, input [8*20-1:0] m);
    begin
      tests_run = tests_run + 1;
      if (c !== 1'b1) begin
        err_total = err_total + 1;
        $display("MISMATCH t=%0t %0s", $time, m);
      end
    end
  endtask
  // one apb transfer; read data and error taken at the ready edge
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge clk) psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk) penable <= 1'b1;
      k = 0;
      do begin @(posedge clk); k = k + 1; end while (pready !== 1'b1 && k < 20);
      if (k == 20) begin chk(1'b0, "apb timeout"); wrap_up; end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  // one select frame, then wait a bounded time for the verdict pulse
  task cmd(input [7:0] c, input [3:0] sc, input [7:0] d, input integer n, input e);
    begin
      host.frame(c, sc, d, n);
      k = 0;
      do begin @(posedge clk); k = k + 1; end while (cmd_accept !== 1'b1 && cmd_reject !== 1'b1 && k < 30);
      if (k == 30) begin chk(1'b0, "command timeout"); wrap_up; end
      chk(cmd_accept === e && cmd_reject === !e, "command outcome");
      repeat (3) @(posedge clk);
    end
  endtask
  task we;
    cmd(`SFP_CMD_WREN, 4'h0, 8'h00, 8, 1'b1);
  endtask
  // sectors covered by the protect range; code 100 with bottom set is 0..7
  function prot(input tb_, input [2:0] bp, input [3:0] sec);
    integer n;
    begin
      n = (bp == 0) ? 0 : (bp < 5) ? (1 << (bp - 1)) : 16;
      prot = tb_ ? (sec < n) : (sec >= 16 - n);
    end
  endfunction
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    chk(power_mode === `SFP_PM_STANDBY && write_enable_latch === 1'b0 && status_reg === 8'h00, "reset");
    apb(1'b0, 12'h020, 32'h0);
    chk(er === 1'b1 && rd === 32'h0, "unmapped read");
    we;
    cmd(`SFP_CMD_SE, 4'h0, 8'h00, 8, 1'b0);
    cmd(`SFP_CMD_WRDI, 4'h0, 8'h00, 8, 1'b1);
    repeat (PUW) @(posedge clk);
    cmd(`SFP_CMD_WREN, 4'h0, 8'h00, 7, 1'b0);
    cmd(`SFP_CMD_WREN, 4'h0, 8'h00, 9, 1'b0);
    cmd(`SFP_CMD_WREN, 4'h0, 8'h00, 16, 1'b1);
    chk(write_enable_latch === 1'b1, "latch set");
    cmd(`SFP_CMD_WRDI, 4'h0, 8'h00, 8, 1'b1);
    cmd(`SFP_CMD_PP, 4'h3, 8'h00, 8, 1'b0);
    we;
    cmd(`SFP_CMD_PP, 4'h3, 8'h00, 40, 1'b1);
    chk(write_enable_latch === 1'b0, "latch cleared");
    $display("test latch and count done");
    for (t = 0; t < 2; t = t + 1)
      for (b = 0; b < 8; b = b + 1) begin
        apb(1'b1, `SFP_OFF_STATUS, (t << 5) | (b << 2));
        apb(1'b0, `SFP_OFF_STATUS, 32'h0);
        chk(rd[7:2] === {2'b00, t[0], b[2:0]}, "status write");
        for (s = 0; s < 16; s = s + 1) begin
          we;
          cmd(`SFP_CMD_SE, s[3:0], 8'h00, 8, !prot(t[0], b[2:0], s[3:0]));
        end
        we;
        cmd(`SFP_CMD_BE, 4'h0, 8'h00, 8, b == 0);
      end
    $display("test protect ranges done");
    apb(1'b1, `SFP_OFF_STATUS, 32'h0);
    apb(1'b1, `SFP_OFF_LOCK, 32'h501);
    we;
    cmd(`SFP_CMD_SE, 4'h5, 8'h00, 8, 1'b0);
    we;
    cmd(`SFP_CMD_SE, 4'h4, 8'h00, 8, 1'b1);
    apb(1'b1, `SFP_OFF_LOCK, 32'h500);
    we;
    cmd(`SFP_CMD_SE, 4'h5, 8'h00, 8, 1'b1);
    apb(1'b1, `SFP_OFF_LOCK, 32'h603);
    apb(1'b1, `SFP_OFF_LOCK, 32'h600);
    apb(1'b1, `SFP_OFF_CTRL, 32'h6);
    apb(1'b0, `SFP_OFF_LOCK, 32'h0);
    chk(rd === 32'h0000_0603, "lock readback");
    we;
    cmd(`SFP_CMD_SE, 4'h6, 8'h00, 8, 1'b0);
    we;
    cmd(`SFP_CMD_WRLR, 4'h6, 8'h00, 40, 1'b0);
    $display("test locks done");
    apb(1'b1, `SFP_OFF_STATUS, 32'h80);
    wp_b <= 1'b0;
    repeat (10) @(posedge clk);
    apb(1'b1, `SFP_OFF_STATUS, 32'h1C);
    apb(1'b0, `SFP_OFF_STATUS, 32'h0);
    chk(rd[7:2] === 6'h20, "status frozen");
    we;
    cmd(`SFP_CMD_WRSR, 4'h0, 8'h00, 16, 1'b0);
    wp_b <= 1'b1;
    repeat (10) @(posedge clk);
    apb(1'b1, `SFP_OFF_STATUS, 32'h0);
    $display("test write protect pin done");
    cycle_busy <= 1'b1;
    cmd(`SFP_CMD_SE, 4'h0, 8'h00, 8, 1'b0);
    chk(power_mode === `SFP_PM_ACTIVE, "active while busy");
    cycle_busy <= 1'b0;
    repeat (6) @(posedge clk);
    chk(power_mode === `SFP_PM_STANDBY, "standby after busy");
    cmd(`SFP_CMD_DPD, 4'h0, 8'h00, 8, 1'b1);
    chk(power_mode === `SFP_PM_DEEP, "deep entered");
    cmd(`SFP_CMD_SE, 4'h0, 8'h00, 8, 1'b0);
    chk(power_mode === `SFP_PM_DEEP && write_enable_latch === 1'b1, "deep kept");
    cmd(`SFP_CMD_RDPD, 4'h0, 8'h00, 8, 1'b1);
    chk(power_mode !== `SFP_PM_DEEP, "deep released");
    $display("test power modes done");
    rst_b <= 1'b0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    repeat (PUW + 10) @(posedge clk);
    we;
    cmd(`SFP_CMD_SE, 4'h6, 8'h00, 8, 1'b1);
    $display("test second power-up done");
    wrap_up;
  end
endmodule
